// ==== pkg/cmd_frame_pkg.sv ====
// Purpose: shared constants and types for the serial flash command front end
// Assumes: mclk at 100 MHz
// Notes: opcodes and address field layout of the framed commands
package cmd_frame_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // power-up timing
  localparam int unsigned SUPPLY_TO_SELECT_WAIT_US = 70;
  localparam int unsigned FIRST_PROGRAM_ERASE_DELAY_MS = 5;
  localparam int unsigned SELECT_WAIT_CYCLES = SUPPLY_TO_SELECT_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PROGRAM_DELAY_CYCLES = FIRST_PROGRAM_ERASE_DELAY_MS * (CLK_HZ / 1_000);
  // address field layout
  localparam int unsigned ADDR_BITS = 24;
  localparam int unsigned LEAD_DUMMY_BITS = 2;
  localparam int unsigned PAGE_BITS = 12;
  localparam int unsigned BYTE_BITS = 10;
  localparam int unsigned BYTE_LSB = 0;
  localparam int unsigned PAGE_LSB = BYTE_BITS;
  // opcodes
  localparam logic [7:0] OP_PAGE_ERASE_BUF1 = 8'h81;
  localparam logic [7:0] OP_PROG_BUF1 = 8'h82;
  localparam logic [7:0] OP_PROG_ERASE_BUF1 = 8'h83;
  localparam logic [7:0] OP_PROG_ERASE_BUF2 = 8'h86;
  localparam logic [7:0] OP_BUF2_WRITE = 8'h87;
  localparam logic [7:0] OP_PROG_NOERASE_BUF1 = 8'h88;
  localparam logic [7:0] OP_PROG_NOERASE_BUF2 = 8'h89;
  localparam logic [7:0] OP_BUF_READ_D1 = 8'hD1;
  localparam logic [7:0] OP_MAIN_READ_D2 = 8'hD2;
  localparam logic [7:0] OP_BUF_READ_D3 = 8'hD3;
  localparam logic [7:0] OP_BUF_READ_D4 = 8'hD4;
  localparam logic [7:0] OP_BUF_READ_D6 = 8'hD6;
  localparam logic [2:0] D2_DUMMY_BYTES = 3'h4;
  localparam logic [2:0] BUF_READ_DUMMY_BYTES = 3'h1;
  // clock mode codes
  localparam logic SPI_MODE0 = 1'b0;
  localparam logic SPI_MODE3 = 1'b1;
  localparam logic RESET_MODE = SPI_MODE3;

  typedef enum logic [1:0] {ADDR_FULL, ADDR_PAGE, ADDR_BYTE, ADDR_NONE} addr_kind_e;

  typedef struct packed {
    addr_kind_e kind;
    logic [2:0] dummy_bytes;
    logic is_program;
  } op_info_s;
endpackage : cmd_frame_pkg

// ==== pkg/frame_if.sv ====
// Purpose: carries a decoded command frame between the front end modules
// Assumes: single clock domain
// Notes: valid is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic valid;
  logic [11:0] page;
  logic [9:0] byte_addr;
  logic [2:0] dummy_bytes;
  logic is_program;
  logic out_valid;
  modport src (output opcode, addr, valid, input page, byte_addr, dummy_bytes, is_program, out_valid);
  modport dec (input opcode, addr, valid, output page, byte_addr, dummy_bytes, is_program, out_valid);
endinterface : frame_if
`default_nettype wire

// ==== hw/addr_field_split.sv ====
// Purpose: splits a 24-bit address field into page and byte parts per opcode
// Assumes: opcode and address valid together for one cycle
// Notes: result registered, one cycle after valid
`timescale 1ns/1ps
`default_nettype none
module addr_field_split
  import cmd_frame_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // frame
  frame_if.dec fr
);
  typedef struct packed {
    logic [11:0] page;
    logic [9:0] byte_addr;
    logic [2:0] dummy_bytes;
    logic is_program;
    logic out_valid;
  } split_s;

  split_s state;
  split_s next_state;

  // address kind and dummy count per opcode
  function automatic op_info_s classify(input logic [7:0] op);
    op_info_s info;
    info = '{kind: ADDR_NONE, dummy_bytes: 3'h0, is_program: 1'b0};
    case (op)
      OP_PROG_BUF1: info = '{ADDR_FULL, 3'h0, 1'b1};
      OP_MAIN_READ_D2: info = '{ADDR_FULL, D2_DUMMY_BYTES, 1'b0};
      OP_PAGE_ERASE_BUF1, OP_PROG_ERASE_BUF2, OP_PROG_NOERASE_BUF1, OP_PROG_NOERASE_BUF2,
      OP_PROG_ERASE_BUF1:
        info = '{ADDR_PAGE, 3'h0, 1'b1};
      OP_BUF2_WRITE, OP_BUF_READ_D1, OP_BUF_READ_D3: info = '{ADDR_BYTE, 3'h0, 1'b0};
      OP_BUF_READ_D4, OP_BUF_READ_D6: info = '{ADDR_BYTE, BUF_READ_DUMMY_BYTES, 1'b0};
      default: info = '{ADDR_NONE, 3'h0, 1'b0};
    endcase
    return info;
  endfunction

  // dummy positions read as zero so ignored bits never leak
  always_comb
  begin
    op_info_s info;
    info = classify(fr.opcode);
    next_state = state;
    next_state.out_valid = fr.valid;
    if (fr.valid)
    begin
      next_state.page = (info.kind == ADDR_FULL || info.kind == ADDR_PAGE) ?
        fr.addr[PAGE_LSB +: PAGE_BITS] : 12'h000;
      next_state.byte_addr = (info.kind == ADDR_FULL || info.kind == ADDR_BYTE) ?
        fr.addr[BYTE_LSB +: BYTE_BITS] : 10'h000;
      next_state.dummy_bytes = info.dummy_bytes;
      next_state.is_program = info.is_program;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      state <= '0;
    else
      state <= next_state;
  end

  assign fr.page = state.page;
  assign fr.byte_addr = state.byte_addr;
  assign fr.dummy_bytes = state.dummy_bytes;
  assign fr.is_program = state.is_program;
  assign fr.out_valid = state.out_valid;
endmodule // addr_field_split
`default_nettype wire

// ==== hw/cmd_frame_front.sv ====
// Purpose: serial flash command front end: framing, mode detect, power-up gating
// Assumes: sck, cs_n, si arrive asynchronously and are sampled by mclk
// Notes: serial output stays released; data return is outside this block
`timescale 1ns/1ps
`default_nettype none
module cmd_frame_front
  import cmd_frame_pkg::*;
#(
  parameter int unsigned PROGRAM_DELAY = PROGRAM_DELAY_CYCLES,
  parameter int unsigned SELECT_WAIT = SELECT_WAIT_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // power-on reset from supply monitor, active high
  input wire logic por_active,
  // serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  // decoded command
  output logic [7:0] opcode,
  output logic [11:0] page,
  output logic [9:0] byte_addr,
  output logic [2:0] dummy_bytes,
  output logic cmd_valid,
  output logic program_start,
  output logic program_deferred,
  // status
  output logic spi_mode,
  output logic standby
);
  import cmd_frame_pkg::*;

  // the power-up counter is 23 bits wide, so longer delays cannot be counted
  if (PROGRAM_DELAY < 1 || PROGRAM_DELAY > 32'h0080_0000)
  begin : g_bad_program_delay
    $error("program delay out of range");
  end
  // the wait itself is kept by the host; a zero wait means a broken setup
  if (SELECT_WAIT < 1)
  begin : g_bad_select_wait
    $error("select wait must be at least one cycle");
  end

  // frame phases; ST_POR holds everything while the supply settles
  typedef enum logic [1:0] {ST_POR, ST_IDLE, ST_OPCODE, ST_ADDR} phase_e;

  typedef struct packed {
    logic [1:0] sck_sync;
    logic [1:0] cs_sync;
    logic [1:0] si_sync;
    logic [1:0] por_sync;
    logic sck_prev;
    logic cs_prev;
    phase_e phase;
    logic [4:0] bit_cnt;
    logic [7:0] op;
    logic [23:0] addr;
    logic addr_valid;
    logic mode;
    logic [22:0] pu_cnt;
    logic pu_done;
    logic first_done;
    logic pend;
    logic prog_start;
    logic deferred;
    logic [7:0] op_out;
    logic [11:0] page_out;
    logic [9:0] byte_out;
    logic [2:0] dummy_out;
    logic valid_out;
    logic standby_out;
    logic so_level;
    logic so_drive;
  } front_s;

  // whole module state, registered in one place
  front_s state;
  front_s next_state;

  // decoded fields come back one cycle after the frame
  frame_if fr ();

  addr_field_split u_split (
    .mclk(mclk),
    .resetn(resetn),
    .fr(fr)
  );

  // opcodes that carry an address field after them
  function automatic logic has_addr(input logic [7:0] op);
    case (op)
      OP_PAGE_ERASE_BUF1, OP_PROG_BUF1, OP_PROG_ERASE_BUF1, OP_PROG_ERASE_BUF2, OP_BUF2_WRITE,
      OP_PROG_NOERASE_BUF1, OP_PROG_NOERASE_BUF2, OP_BUF_READ_D1, OP_MAIN_READ_D2,
      OP_BUF_READ_D3, OP_BUF_READ_D4, OP_BUF_READ_D6:
        has_addr = 1'b1;
      default:
        has_addr = 1'b0;
    endcase
  endfunction

  // captured opcode and address go to the splitter as one frame
  assign fr.opcode = state.op;
  assign fr.addr = state.addr;
  assign fr.valid = state.addr_valid;

  // main sequencing; edges taken only from second sync stage
  always_comb
  begin
    logic sck_rise;
    logic cs_fall;
    logic cs_rise;
    logic por;
    sck_rise = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    por = 1'b0;
    next_state = state;
    next_state.sck_sync = {state.sck_sync[0], sck};
    next_state.cs_sync = {state.cs_sync[0], cs_n};
    next_state.si_sync = {state.si_sync[0], si};
    next_state.por_sync = {state.por_sync[0], por_active};
    next_state.sck_prev = state.sck_sync[1];
    next_state.cs_prev = state.cs_sync[1];
    next_state.addr_valid = 1'b0;
    next_state.prog_start = 1'b0;
    // no command here returns data, so the output pin stays released
    next_state.so_level = 1'b0;
    next_state.so_drive = 1'b0;
    sck_rise = state.sck_sync[1] && !state.sck_prev;
    cs_fall = !state.cs_sync[1] && state.cs_prev;
    cs_rise = state.cs_sync[1] && !state.cs_prev;
    por = state.por_sync[1];

    // power-up delay counter runs from power-on reset release
    if (!state.pu_done)
    begin
      if (state.pu_cnt >= 23'(PROGRAM_DELAY - 1))
        next_state.pu_done = 1'b1;
      else
        next_state.pu_cnt = state.pu_cnt + 23'h000001;
    end

    // a deferred first program is released once the delay runs out
    if (state.pend && state.pu_done)
    begin
      next_state.pend = 1'b0;
      next_state.prog_start = 1'b1;
      next_state.deferred = 1'b0;
    end

    case (state.phase)
      ST_POR:
      begin
        if (!por)
        begin
          next_state.phase = ST_IDLE;
          next_state.standby_out = 1'b1;
        end
      end
      ST_IDLE:
      begin
        // only a select fall seen after reset can open a command
        if (cs_fall)
        begin
          next_state.mode = state.sck_sync[1] ? SPI_MODE3 : SPI_MODE0;
          next_state.phase = ST_OPCODE;
          next_state.bit_cnt = 5'h00;
          next_state.standby_out = 1'b0;
        end
      end
      ST_OPCODE:
      begin
        if (sck_rise)
        begin
          next_state.op = {state.op[6:0], state.si_sync[1]};
          next_state.bit_cnt = state.bit_cnt + 5'h01;
          if (state.bit_cnt == 5'h07)
          begin
            next_state.bit_cnt = 5'h00;
            // without an address the frame is over; later bits are ignored
            if (has_addr({state.op[6:0], state.si_sync[1]}))
              next_state.phase = ST_ADDR;
            else
              next_state.phase = ST_IDLE;
          end
        end
      end
      ST_ADDR:
      begin
        if (sck_rise)
        begin
          next_state.addr = {state.addr[22:0], state.si_sync[1]};
          next_state.bit_cnt = state.bit_cnt + 5'h01;
          if (state.bit_cnt == 5'(ADDR_BITS - 1))
          begin
            next_state.addr_valid = 1'b1;
            next_state.phase = ST_IDLE;
          end
        end
      end
      default:
        next_state.phase = ST_POR;
    endcase

    // select rising aborts any partial frame
    if (cs_rise && state.phase != ST_POR)
    begin
      next_state.phase = ST_IDLE;
      next_state.standby_out = 1'b1;
    end

    // decoded frame back from the splitter
    if (fr.out_valid)
    begin
      next_state.op_out = state.op;
      next_state.page_out = fr.page;
      next_state.byte_out = fr.byte_addr;
      next_state.dummy_out = fr.dummy_bytes;
      next_state.valid_out = 1'b1;
      if (fr.is_program && !state.first_done)
      begin
        next_state.first_done = 1'b1;
        if (!state.pu_done)
        begin
          next_state.pend = 1'b1;
          next_state.deferred = 1'b1;
        end
        else
          next_state.prog_start = 1'b1;
      end
      else if (fr.is_program)
        next_state.prog_start = 1'b1;
    end
    else
      next_state.valid_out = 1'b0;

    // power-on reset wipes any command and blocks the interface
    if (por)
    begin
      next_state.phase = ST_POR;
      next_state.standby_out = 1'b0;
      next_state.addr_valid = 1'b0;
      next_state.valid_out = 1'b0;
      next_state.prog_start = 1'b0;
      next_state.pend = 1'b0;
      next_state.deferred = 1'b0;
      next_state.mode = RESET_MODE;
      // a fresh power-up restarts the first program delay
      next_state.pu_cnt = 23'h000000;
      next_state.pu_done = 1'b0;
      next_state.first_done = 1'b0;
    end
  end

  // idle levels after reset, so no false select or power-up edge follows
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= '0;
      state.phase <= ST_POR;
      state.mode <= RESET_MODE;
      state.sck_sync <= 2'h3;
      state.cs_sync <= 2'h3;
      state.sck_prev <= 1'b1;
      state.cs_prev <= 1'b1;
      state.por_sync <= 2'h3;
    end
    else
      state <= next_state;
  end

  // output driven low but released; nothing in this block returns data
  assign so_out = state.so_level;
  assign so_oe = state.so_drive;
  assign opcode = state.op_out;
  assign page = state.page_out;
  assign byte_addr = state.byte_out;
  assign dummy_bytes = state.dummy_out;
  assign cmd_valid = state.valid_out;
  assign program_start = state.prog_start;
  assign program_deferred = state.deferred;
  assign spi_mode = state.mode;
  assign standby = state.standby_out;
endmodule // cmd_frame_front
`default_nettype wire

// ==== tb/cmd_frame_monitor.sv ====
// Purpose: port checker for the command front end
// Assumes: bound to cmd_frame_front, one clock domain
// Notes: reset disables every property
`timescale 1ns/1ps
`default_nettype none
module cmd_frame_monitor
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // inputs
  input wire logic por_active,
  input wire logic cs_n,
  input wire logic sck,
  // outputs
  input wire logic so_oe,
  input wire logic [7:0] opcode,
  input wire logic [11:0] page,
  input wire logic [9:0] byte_addr,
  input wire logic [2:0] dummy_bytes,
  input wire logic cmd_valid,
  input wire logic spi_mode,
  input wire logic standby
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // opcode groups whose address half is dummy
  wire logic pg_only = opcode inside {8'h81, 8'h83, 8'h86, 8'h88, 8'h89};
  wire logic bf_only = opcode inside {8'h87, 8'hD1, 8'hD3, 8'hD4, 8'hD6};
  property p_so_off; so_oe == 1'b0; endproperty
  property p_mode_rst; $rose(resetn) |-> spi_mode; endproperty
  property p_por; por_active [*5] |-> !standby && !cmd_valid; endproperty
  property p_pulse; cmd_valid |=> !cmd_valid; endproperty
  property p_dummy;
    cmd_valid |-> dummy_bytes == (opcode == 8'hD2 ? 3'h4 : opcode inside {8'hD4, 8'hD6} ? 3'h1 : 3'h0);
  endproperty
  property p_pg_only; cmd_valid && pg_only |-> byte_addr == 10'h0; endproperty
  property p_bf_only; cmd_valid && bf_only |-> page == 12'h0; endproperty
  // mode is the idle clock level seen as select falls
  property p_mode_cap; standby && $fell(cs_n) |-> ##4 spi_mode == $past(sck, 4); endproperty
  property p_leave; standby && $fell(cs_n) |-> ##[2:5] !standby; endproperty
  a_so_off: assert property (p_so_off) else $error("output enabled");
  a_mode_rst: assert property (p_mode_rst) else $error("mode not 3 after reset");
  a_por: assert property (p_por) else $error("active under por");
  a_pulse: assert property (p_pulse) else $error("valid too long");
  a_dummy: assert property (p_dummy) else $error("dummy count");
  a_pg_only: assert property (p_pg_only) else $error("byte bits kept");
  a_bf_only: assert property (p_bf_only) else $error("page bits kept");
  a_mode_cap: assert property (p_mode_cap) else $error("mode capture");
  a_leave: assert property (p_leave) else $error("standby kept");
  c_frame: cover property (cmd_valid);
  c_mode0: cover property (cmd_valid && !spi_mode);
  c_por: cover property (por_active && !standby);
endmodule // cmd_frame_monitor
`default_nettype wire

// ==== tb/spi_host_model.sv ====
// Purpose: host controller model driving the serial pins
// Assumes: sck period 130 ns as 6 plus 7 mclk cycles
// Notes: pins move on mclk falling edges; between frames sck only moves to the next frame's idle level
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
  // clock
  input wire logic mclk,
  // serial pins
  output logic sck,
  output logic cs_n,
  output logic si
);
  initial
  begin
    sck = 1'b1;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // whole mclk cycles
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // one select, top n bits of word, msb first
  task automatic xfer(input logic mode3, input logic [31:0] word, input int n);
    sck = mode3;
    hold(7);
    cs_n = 1'b0;
    hold(6);
    for (int i = 31; i > 31 - n; i--)
    begin
      sck = 1'b0;
      si = word[i];
      hold(6);
      sck = 1'b1;
      hold(7);
    end
    sck = mode3;
    hold(6);
    cs_n = 1'b1;
    si = ~si; // released line must not keep its last bit
    hold(13);
  endtask
endmodule // spi_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the command front end
// Assumes: host model on the serial pins
// Notes: short power-up delay so the run stays small
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cmd_frame_pkg::*;
  localparam int unsigned PDELAY = 2000;
  localparam int unsigned SWAIT = 20;
  logic mclk;
  logic resetn;
  logic por_active;
  logic sck, cs_n, si, so_out, so_oe, cmd_valid, program_start, program_deferred, spi_mode, standby;
  logic [7:0] opcode;
  logic [11:0] page;
  logic [9:0] byte_addr;
  logic [2:0] dummy_bytes;
  int bad_count = 0;
  int cmp_count = 0;
  int frames = 0;
  int starts = 0;
  cmd_frame_front #(.PROGRAM_DELAY(PDELAY), .SELECT_WAIT(SWAIT)) dut_u (.mclk, .resetn, .por_active, .sck,
    .cs_n, .si, .so_out, .so_oe, .opcode, .page, .byte_addr, .dummy_bytes, .cmd_valid, .program_start,
    .program_deferred, .spi_mode, .standby);
  spi_host_model host_u (.mclk, .sck, .cs_n, .si);
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // pulse counters, judged after each frame
  always @(posedge mclk)
  begin
    frames <= frames + int'(cmd_valid === 1'b1);
    starts <= starts + int'(program_start === 1'b1);
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %0h", $time, what, got);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic t_power;
    int f;
    resetn = 1'b0;
    por_active = 1'b1;
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    chk(so_oe, 0, "oe");
    chk(so_out, 0, "so level");
    chk(spi_mode, 1, "reset mode");
    f = frames;
    host_u.xfer(1'b0, 32'h8200_0000, 32);
    chk(12'(frames - f), 0, "frame under por");
    chk(standby, 0, "standby under por");
    por_active = 1'b0;
    for (int n = 0; n < 50 && standby !== 1'b1; n++)
      @(negedge mclk);
    chk(standby, 1, "standby");
    repeat (SWAIT) @(negedge mclk);
    $display("power test done");
  endtask
  task automatic t_program;
    int s;
    s = starts;
    host_u.xfer(1'b1, 32'h8200_0400, 32);
    chk(program_deferred, 1, "deferred");
    chk(12'(starts - s), 0, "early start");
    for (int n = 0; n < PDELAY && starts == s; n++)
      @(negedge mclk);
    chk(12'(starts - s), 1, "late start");
    chk(program_deferred, 0, "deferred cleared");
    host_u.xfer(1'b1, 32'h8800_0800, 32);
    chk(12'(starts - s), 2, "second start");
    $display("program test done");
  endtask
  task automatic t_abort;
    int f;
    f = frames;
    host_u.xfer(1'b0, 32'hD23F_FFFF, 20);
    chk(12'(frames - f), 0, "aborted frame");
    $display("abort test done");
  endtask
  task automatic t_frames;
    logic [7:0] ops [12] = '{8'h81, 8'h82, 8'h86, 8'h87, 8'h88, 8'h89, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD6, 8'h83};
    logic [23:0] a;
    int f;
    for (int i = 0; i < 12; i++)
    begin
      a = {2'b11, 12'hA50 + 12'(i), 10'h2C3 + 10'(i)};
      f = frames;
      host_u.xfer(i[0], {ops[i], a}, 32);
      chk(12'(frames - f), 1, "frame");
      chk(opcode, ops[i], "opcode");
      chk(spi_mode, i[0], "mode");
      chk(page, ops[i] inside {8'h87, 8'hD1, 8'hD3, 8'hD4, 8'hD6} ? 12'h0 : a[21:10], "page");
      chk(byte_addr, ops[i] inside {8'h81, 8'h83, 8'h86, 8'h88, 8'h89} ? 10'h0 : a[9:0], "byte");
      chk(dummy_bytes, ops[i] == 8'hD2 ? 3'h4 : ops[i] inside {8'hD4, 8'hD6} ? 3'h1 : 3'h0, "dummy");
    end
    $display("frame test done");
  endtask
  initial
  begin
    t_power;
    t_program;
    t_abort;
    t_frames;
    summarize;
  end
  // watchdog: run needs some 9k cycles
  initial
  begin
    #500_000;
    bad_count++;
    summarize;
  end
endmodule // testbench
bind cmd_frame_front cmd_frame_monitor mon_u (.mclk, .resetn, .por_active, .cs_n, .sck, .so_oe, .opcode,
  .page, .byte_addr, .dummy_bytes, .cmd_valid, .spi_mode, .standby);
`default_nettype wire
